// ### src/fdp_dsel_dec.sv
// Drive select decoder: one-hot drive number gated by motor enables.
// Assumes a stable drive output control value at its input.
`timescale 1ns/100ps

module fdp_dsel_dec (
    input  wire logic [7:0] outctl_in, // Drive output control value
    output logic      [3:0] dsel_out  // Decoded, gated drive selects
);

    // ==========================================================
    // Decode
    logic [1:0] unit;
    logic [3:0] onehot;

    // Pick the unit number and its matching enable
    always_comb begin
        unit     = outctl_in[fdp_pkg::FDP_OUTCTL_SEL_LO +: 2];
        onehot   = 4'h1 << unit;
        dsel_out = onehot &
                   outctl_in[fdp_pkg::FDP_OUTCTL_MOTOR_LO +: 4];
    end

endmodule

// ### src/fdp_pkg.sv
// Constants, types and state layout for the drive-pin and DMA handshake
// block. Assumes every user sits in the sys_clk_in domain.
package fdp_pkg;

    // ==========================================================
    // Host interface modes
    localparam logic [1:0] FDP_MODE_LEGACY   = 2'h0;
    localparam logic [1:0] FDP_MODE_COMPACT  = 2'h1;
    localparam logic [1:0] FDP_MODE_ENHANCED = 2'h2;

    // ==========================================================
    // Drive output control register layout and reset value
    localparam int         FDP_OUTCTL_DMA_EN_BIT = 3;
    localparam int         FDP_OUTCTL_SEL_LO     = 0;
    localparam int         FDP_OUTCTL_MOTOR_LO   = 4;
    localparam logic [7:0] FDP_OUTCTL_RESET      = 8'h00;

    // ==========================================================
    // Rate codes, reset rate and density select modes
    localparam logic [1:0] FDP_RATE_500K  = 2'h0;
    localparam logic [1:0] FDP_RATE_300K  = 2'h1;
    localparam logic [1:0] FDP_RATE_250K  = 2'h2;
    localparam logic [1:0] FDP_RATE_1M    = 2'h3;
    localparam logic [1:0] FDP_RATE_RESET = FDP_RATE_250K;

    localparam logic [1:0] FDP_DENS_AUTO     = 2'h0;
    localparam logic [1:0] FDP_DENS_FORCE_HI = 2'h1;
    localparam logic [1:0] FDP_DENS_FORCE_LO = 2'h2;

    // ==========================================================
    // DMA handshake states
    typedef enum logic [2:0] {
        FDP_ST_IDLE = 3'b001,
        FDP_ST_REQ  = 3'b010,
        FDP_ST_XFER = 3'b100
    } fdp_dma_e;

    // ==========================================================
    // Carriers for grouped inputs
    typedef struct packed {
        logic seek_active;
        logic seek_inward;
        logic rw_active;
    } fdp_head_s;

    typedef struct packed {
        logic [1:0] dens_mode;
        logic       mc_as_rdgate;
    } fdp_modecfg_s;

    // ==========================================================
    // Whole state of the top module
    typedef struct packed {
        fdp_dma_e   fsm;
        logic       pending;
        logic [7:0] outctl;
        logic [1:0] rate;
        logic       strap;
        logic       dma_req;
        logic       dma_rd;
        logic       dma_wr;
        logic       reg_rd;
        logic       reg_wr;
        logic [2:0] reg_addr;
        logic       dens_lvl;
        logic       step_dir;
        logic [3:0] dsel;
        logic       unit2;
        logic       media;
        logic       rdgate;
        logic       done;
    } fdp_state_s;

    localparam fdp_state_s FDP_STATE_RESET = '{
        fsm: FDP_ST_IDLE, pending: 1'b0, outctl: FDP_OUTCTL_RESET,
        rate: FDP_RATE_RESET, strap: 1'b0, dma_req: 1'b0, dma_rd: 1'b0,
        dma_wr: 1'b0, reg_rd: 1'b0, reg_wr: 1'b0, reg_addr: 3'h0,
        dens_lvl: 1'b0, step_dir: 1'b0, dsel: 4'h0, unit2: 1'b0,
        media: 1'b0, rdgate: 1'b0, done: 1'b0};

endpackage

// ### src/fdp_top.sv
// DMA handshake gating and drive-side pin logic of a disk controller.
// Assumes all inputs synchronous to sys_clk_in; the engine asks for bytes.
// Operation
// - Acknowledge low enables strobes for DMA
// - Legacy, compact modes: DMA gated by bit 3
// - Enhanced mode: DMA always on, bit 3 reserved
// - Request output active high when byte needed
// - Density high at 500k or 1M rates
// - Density polarity follows drive type strap
// - Mode setting may override density output
// - Step direction active inward during seek
// - Step direction inactive during reads, writes
// - Four drive selects decoded from bits 0-1
// - Each select gated by its bit 4-7
// - Rate pins follow last written rate bits
// - Enhanced mode shows second unit present
// - Media change level readable by software
// - Media change input may become read gate
// - Address lines ignored during DMA cycles
`timescale 1ns/100ps

module fdp_top (
    input  wire logic                 sys_clk_in,      // 250 MHz clock
    input  wire logic                 rst_in,          // Sync reset, high
    input  wire logic [1:0]           host_mode_in,    // Host mode code
    input  wire logic                 drive_type_strap_in, // Caught at reset
    input  wire logic                 outctl_write_in, // Control reg write
    input  wire logic [7:0]           outctl_data_in,  // Control reg data
    input  wire logic                 cfg_write_in,    // Config reg write
    input  wire logic [1:0]           cfg_data_in,     // Config rate bits
    input  wire logic                 dsr_write_in,    // Rate reg write
    input  wire logic [1:0]           dsr_data_in,     // Rate reg bits
    input  wire logic                 byte_needed_in,  // Engine wants byte
    input  wire logic                 dma_ack_n_in,    // DMA acknowledge
    input  wire logic                 cs_n_in,         // Chip select
    input  wire logic                 rd_n_in,         // Read strobe
    input  wire logic                 wr_n_in,         // Write strobe
    input  wire logic [2:0]           reg_addr_lines_in, // Register address
    input  wire fdp_pkg::fdp_head_s   head_in,         // Seek, r/w status
    input  wire fdp_pkg::fdp_modecfg_s modecfg_in,     // Mode settings
    input  wire logic                 second_unit_present_in, // Unit 2 pin
    input  wire logic                 media_change_in, // Door opened pin
    output logic                      dma_request_line_out, // DMA request
    output logic                      dma_rd_strobe_out, // DMA read cycle
    output logic                      dma_wr_strobe_out, // DMA write cycle
    output logic                      reg_rd_strobe_out, // Register read
    output logic                      reg_wr_strobe_out, // Register write
    output logic [2:0]                reg_addr_out,    // Latched address
    output logic                      byte_done_out,   // Byte moved pulse
    output logic                      density_select_out, // Density pin
    output logic                      step_dir_out,    // Step direction
    output logic [3:0]                drive_select_outs_out, // Selects
    output logic                      rate_code_out_lo, // Rate bit 0
    output logic                      rate_code_out_hi, // Rate bit 1
    output logic                      status_a_unit2_out, // Unit 2 status
    output logic                      dir_media_change_out, // Media status
    output logic                      read_gate_diag_out // Read gate diag
);

    // ==========================================================
    // Helpers
    function automatic logic dma_on(input logic [1:0] mode,
                                    input logic [7:0] ctl);
        dma_on = (mode == fdp_pkg::FDP_MODE_ENHANCED) ? 1'b1
               : ctl[fdp_pkg::FDP_OUTCTL_DMA_EN_BIT];
    endfunction

    function automatic logic high_density(input logic [1:0] rate);
        high_density = (rate == fdp_pkg::FDP_RATE_500K) ||
                       (rate == fdp_pkg::FDP_RATE_1M);
    endfunction

    // ==========================================================
    // State
    fdp_pkg::fdp_state_s s;
    fdp_pkg::fdp_state_s next_s;
    logic                dma_en;
    logic                ack_eff;
    logic                strobe_low;
    logic                hd;
    logic [3:0]          dsel_dec;

    // Drive select decoding from the stored control value
    fdp_dsel_dec u_dsel (
        .outctl_in (s.outctl),
        .dsel_out  (dsel_dec)
    );

    // Qualified acknowledge and strobe activity
    always_comb begin
        dma_en     = dma_on(host_mode_in, s.outctl);
        ack_eff    = !dma_ack_n_in && dma_en;
        strobe_low = !rd_n_in || !wr_n_in;
        hd         = high_density(s.rate);
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.done = 1'b0;
        // New byte request; a request arriving while one clears wins
        next_s.pending = s.pending || byte_needed_in;
        case (s.fsm)
            fdp_pkg::FDP_ST_IDLE: begin
                if (s.pending && dma_en) begin
                    next_s.fsm     = fdp_pkg::FDP_ST_REQ;
                    next_s.pending = byte_needed_in;
                end
            end
            fdp_pkg::FDP_ST_REQ: begin
                if (ack_eff && strobe_low) begin
                    next_s.fsm = fdp_pkg::FDP_ST_XFER;
                end
            end
            fdp_pkg::FDP_ST_XFER: begin
                // Strobe released: byte moved, drop the request
                if (!strobe_low) begin
                    next_s.fsm  = fdp_pkg::FDP_ST_IDLE;
                    next_s.done = 1'b1;
                end
            end
            default: begin
                next_s.fsm = fdp_pkg::FDP_ST_IDLE;
            end
        endcase
        next_s.dma_req = (next_s.fsm != fdp_pkg::FDP_ST_IDLE) &&
                         (next_s.fsm != fdp_pkg::FDP_ST_XFER || strobe_low)
                         && dma_en;
        // DMA strobes need the acknowledge, register ones need select
        next_s.dma_rd = ack_eff && !rd_n_in;
        next_s.dma_wr = ack_eff && !wr_n_in;
        next_s.reg_rd = !cs_n_in && !ack_eff && !rd_n_in;
        next_s.reg_wr = !cs_n_in && !ack_eff && !wr_n_in;
        if (!cs_n_in && !ack_eff) begin
            next_s.reg_addr = reg_addr_lines_in;
        end
        // Register writes; the rate holds the last write, a rate reg write winning over a config write in the same cycle
        if (outctl_write_in) begin
            next_s.outctl = outctl_data_in;
        end
        if (dsr_write_in) begin
            next_s.rate = dsr_data_in;
        end else if (cfg_write_in) begin
            next_s.rate = cfg_data_in;
        end
        // Density level: asserted level equals the strap
        case (modecfg_in.dens_mode)
            fdp_pkg::FDP_DENS_FORCE_HI: next_s.dens_lvl = s.strap;
            fdp_pkg::FDP_DENS_FORCE_LO: next_s.dens_lvl = !s.strap;
            default: next_s.dens_lvl = hd ~^ s.strap;
        endcase
        next_s.step_dir = head_in.seek_active && head_in.seek_inward &&
                          !head_in.rw_active;
        next_s.dsel  = dsel_dec;
        next_s.unit2 = (host_mode_in == fdp_pkg::FDP_MODE_ENHANCED) &&
                       second_unit_present_in;
        next_s.media = !modecfg_in.mc_as_rdgate && media_change_in;
        next_s.rdgate = modecfg_in.mc_as_rdgate && media_change_in;
        // Reset loads constants and catches the strap
        if (rst_in) begin
            next_s = fdp_pkg::FDP_STATE_RESET;
            next_s.strap = drive_type_strap_in;
        end
    end

    // Register the whole state
    always_ff @(posedge sys_clk_in) begin
        s <= next_s;
    end

    // ==========================================================
    // Outputs straight from flops
    assign dma_request_line_out  = s.dma_req;
    assign dma_rd_strobe_out     = s.dma_rd;
    assign dma_wr_strobe_out     = s.dma_wr;
    assign reg_rd_strobe_out     = s.reg_rd;
    assign reg_wr_strobe_out     = s.reg_wr;
    assign reg_addr_out          = s.reg_addr;
    assign byte_done_out         = s.done;
    assign density_select_out    = s.dens_lvl;
    assign step_dir_out          = s.step_dir;
    assign drive_select_outs_out = s.dsel;
    assign rate_code_out_lo      = s.rate[0];
    assign rate_code_out_hi      = s.rate[1];
    assign status_a_unit2_out    = s.unit2;
    assign dir_media_change_out  = s.media;
    assign read_gate_diag_out    = s.rdgate;

    // ==========================================================
    // Assertions
    a_req_gated_off: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) !dma_en |=> !dma_request_line_out)
        else $error("DMA request while DMA disabled");

    a_enh_req_on: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (host_mode_in == fdp_pkg::FDP_MODE_ENHANCED &&
         s.fsm == fdp_pkg::FDP_ST_REQ && !strobe_low)
        |=> dma_request_line_out)
        else $error("Enhanced mode request not driven");

    a_ack_rd_strobe: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (!dma_ack_n_in && dma_en && !rd_n_in) |=>
        dma_rd_strobe_out && !reg_rd_strobe_out)
        else $error("Acknowledged read not passed as DMA strobe");

    a_req_withdraw: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (s.fsm == fdp_pkg::FDP_ST_XFER && rd_n_in && wr_n_in)
        |=> byte_done_out && !dma_request_line_out ##1 !byte_done_out)
        else $error("Request not withdrawn after byte");

    a_dens_auto: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (modecfg_in.dens_mode == fdp_pkg::FDP_DENS_AUTO)
        |=> density_select_out == ($past(hd) ~^ s.strap))
        else $error("Density level wrong for rate and strap");

    a_dens_force: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        (modecfg_in.dens_mode == fdp_pkg::FDP_DENS_FORCE_HI)
        |=> density_select_out == s.strap)
        else $error("Forced density level wrong");

    a_dir_rw_idle: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) head_in.rw_active |=> !step_dir_out)
        else $error("Step direction active during read or write");

    a_dsel_gate: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        !s.outctl[fdp_pkg::FDP_OUTCTL_MOTOR_LO] |=> !drive_select_outs_out[0])
        else $error("Drive select active without its enable");

    a_rate_last: assert property (@(posedge sys_clk_in)
        disable iff (rst_in)
        dsr_write_in |=> {rate_code_out_hi, rate_code_out_lo} ==
        $past(dsr_data_in))
        else $error("Rate pins miss last rate write");

    a_addr_dma_hold: assert property (@(posedge sys_clk_in)
        disable iff (rst_in) ack_eff |=> $stable(reg_addr_out))
        else $error("Address latched during DMA cycle");

endmodule

// ### testbench/fdp_dma_partner.sv
// Behavioural system DMA controller facing the block's request pin.
// Assumes one clock and a sync active-high reset; never touches cs_n.
`timescale 1ns/100ps

module fdp_dma_partner (
    input  wire logic       clk_in,    // Bench clock
    input  wire logic       rst_in,    // Sync reset, high
    input  wire logic       req_in,    // DMA request from block
    input  wire logic       dir_wr_in, // 1 write cycles, 0 read cycles
    input  wire logic [3:0] lat_in,    // Cycles waited before answering
    output logic            ack_n_out = 1'b1, // Acknowledge, low active
    output logic            rd_n_out = 1'b1,  // Read strobe, low active
    output logic            wr_n_out = 1'b1,  // Write strobe, low active
    output integer          bytes_out = 0     // Bytes moved so far
);
    logic [1:0] st = 2'h0;
    logic [3:0] cnt = 4'h0;

    // ==========================================================
    // One request, one acknowledged strobe, one byte
    always @(posedge clk_in) begin
        if (rst_in) begin
            st <= 2'h0;
            cnt <= 4'h0;
            ack_n_out <= 1'b1;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
        end else begin
            case (st)
                2'h0: if (req_in) begin
                    cnt <= cnt + 4'h1;
                    if (cnt >= lat_in) begin
                        ack_n_out <= 1'b0;
                        rd_n_out <= dir_wr_in;
                        wr_n_out <= !dir_wr_in;
                        cnt <= 4'h0;
                        st <= 2'h1;
                    end
                end
                2'h1: begin
                    cnt <= cnt + 4'h1;
                    if (cnt == 4'h2) begin
                        rd_n_out <= 1'b1;
                        wr_n_out <= 1'b1;
                        st <= 2'h2;
                    end
                end
                2'h2: begin
                    ack_n_out <= 1'b1;
                    bytes_out <= bytes_out + 1;
                    st <= 2'h3;
                end
                default: if (!req_in) begin
                    cnt <= 4'h0;
                    st <= 2'h0;
                end
            endcase
        end
    end
endmodule

// ### testbench/fdp_top_tb_top.sv
// Self-checking bench for the drive-pin and DMA handshake block.
// Assumes fdp_dma_partner plays the system DMA controller.
`timescale 1ns/100ps

module fdp_top_tb_top;
    logic       clk = 1'b0, rst = 1'b1, strap = 1'b0, need = 1'b0;
    logic [1:0] hmode = 2'h0, cfg_d = 2'h0, dsr_d = 2'h0;
    logic       oc_w = 1'b0, cfg_w = 1'b0, dsr_w = 1'b0, p_wr = 1'b0;
    logic [7:0] oc_d = 8'h00;
    logic       t_ack_n = 1'b1, t_rd_n = 1'b1, t_wr_n = 1'b1, cs_n = 1'b1;
    logic [2:0] addr = 3'h0, raddr, e_addr;
    logic       unit2 = 1'b0, media = 1'b0, p_ack_n, p_rd_n, p_wr_n;
    logic [3:0] p_lat = 4'h0, dsel, e_dsel;
    logic       req, drd, dwr, rrd, rwr, done, dens, sdir, rlo, rhi;
    logic       s_unit2, smed, rdgate, chk_on = 1'b0, m_strap;
    logic       e_dens, e_step, e_stepv, e_unit2, e_med, e_rg, e_rrd, e_rwr;
    logic [7:0] m_oc;
    logic [1:0] m_rate;
    fdp_pkg::fdp_head_s    head = '0;
    fdp_pkg::fdp_modecfg_s mcfg = '0;
    integer     n_bytes, num_errors = 0, n_compared = 0, seed = 32'h04f9;
    integer     exp_bytes = 0, k;
    wire logic  ack_n = p_ack_n & t_ack_n;
    wire logic  rd_n = p_rd_n & t_rd_n;
    wire logic  wr_n = p_wr_n & t_wr_n;

    always #2 clk = ~clk;

    fdp_top i_dut (.sys_clk_in(clk), .rst_in(rst), .host_mode_in(hmode),
        .drive_type_strap_in(strap), .outctl_write_in(oc_w),
        .outctl_data_in(oc_d), .cfg_write_in(cfg_w), .cfg_data_in(cfg_d),
        .dsr_write_in(dsr_w), .dsr_data_in(dsr_d), .byte_needed_in(need),
        .dma_ack_n_in(ack_n), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .reg_addr_lines_in(addr), .head_in(head), .modecfg_in(mcfg),
        .second_unit_present_in(unit2), .media_change_in(media),
        .dma_request_line_out(req), .dma_rd_strobe_out(drd),
        .dma_wr_strobe_out(dwr), .reg_rd_strobe_out(rrd),
        .reg_wr_strobe_out(rwr), .reg_addr_out(raddr), .byte_done_out(done),
        .density_select_out(dens), .step_dir_out(sdir),
        .drive_select_outs_out(dsel), .rate_code_out_lo(rlo),
        .rate_code_out_hi(rhi), .status_a_unit2_out(s_unit2),
        .dir_media_change_out(smed), .read_gate_diag_out(rdgate));

    fdp_dma_partner i_dma (.clk_in(clk), .rst_in(rst), .req_in(req),
        .dir_wr_in(p_wr), .lat_in(p_lat), .ack_n_out(p_ack_n),
        .rd_n_out(p_rd_n), .wr_n_out(p_wr_n), .bytes_out(n_bytes));

    task automatic check(input string nm, input logic [7:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // ==========================================================
    // Reference model of the pin outputs, one edge behind inputs
    always @(posedge clk) begin
        chk_on <= !rst;
        if (rst) begin
            m_oc <= fdp_pkg::FDP_OUTCTL_RESET;
            m_rate <= fdp_pkg::FDP_RATE_RESET;
            m_strap <= strap;
        end else begin
            if (oc_w) m_oc <= oc_d;
            if (dsr_w) m_rate <= dsr_d;
            else if (cfg_w) m_rate <= cfg_d;
        end
        e_dsel <= m_oc[7:4] & (4'h1 << m_oc[1:0]);
        e_dens <= m_strap ^ !(mcfg.dens_mode == 2'h1 ||
            (mcfg.dens_mode == 2'h0 && (m_rate == 2'h0 || m_rate == 2'h3)));
        e_stepv <= head.seek_active | head.rw_active;
        e_step <= head.seek_active & head.seek_inward & !head.rw_active;
        e_unit2 <= hmode == fdp_pkg::FDP_MODE_ENHANCED && unit2;
        e_med <= !mcfg.mc_as_rdgate && media;
        e_rg <= mcfg.mc_as_rdgate && media;
        e_rrd <= !cs_n && !rd_n;
        e_rwr <= !cs_n && !wr_n;
        e_addr <= rst ? 3'h0 : (!cs_n ? addr : e_addr);
    end

    // Compare the settled drive-side and register pin outputs against the model, step direction only during seek or read/write
    always @(negedge clk) if (chk_on) begin
        check("dsel", dsel, e_dsel);
        check("density", dens, e_dens);
        if (e_stepv) check("stepdir", sdir, e_step);
        check("rate", {rhi, rlo}, m_rate);
        check("unit2", s_unit2, e_unit2);
        check("media", smed, e_med);
        check("rdgate", rdgate, e_rg);
        check("regrd", {rrd, rwr}, {e_rrd, e_rwr});
        check("regaddr", raddr, e_addr);
    end

    task automatic rand_phase(input integer n);
        repeat (n) begin
            @(posedge clk);
            hmode <= 2'($unsigned($random(seed)) % 3);
            oc_w <= ($random(seed) & 3) == 0;
            oc_d <= 8'($random(seed));
            {cfg_w, dsr_w, cfg_d, dsr_d} <= 6'($random(seed));
            {cs_n, t_rd_n, t_wr_n, addr} <= 6'($random(seed));
            head <= 3'($random(seed));
            mcfg <= {2'($unsigned($random(seed)) % 3), 1'($random(seed))};
            {unit2, media} <= 2'($random(seed));
        end
        @(posedge clk);
        {cs_n, t_rd_n, t_wr_n, oc_w, cfg_w, dsr_w} <= 6'b111000;
    endtask

    task automatic dma_byte(input logic [1:0] md, input logic d3, w,
                            input logic [3:0] lat);
        integer i;
        logic   sr, ss;
        @(posedge clk);
        {hmode, oc_w, oc_d, p_wr, p_lat, need} <= {md, 1'b1, 4'h0, d3,
            3'h0, w, lat, 1'b1};
        addr <= 3'($random(seed));
        @(posedge clk);
        {oc_w, need} <= 2'b00;
        exp_bytes++;
        if (md != fdp_pkg::FDP_MODE_ENHANCED && !d3) begin
            {t_ack_n, t_rd_n, t_wr_n} <= {1'b0, w, !w};
            repeat (6) begin
                @(negedge clk);
                check("req off", req, 1'b0);
                check("strobe off", {drd, dwr}, 2'b00);
            end
            @(posedge clk);
            {t_ack_n, t_rd_n, t_wr_n, oc_w, oc_d} <= {4'b1111, 8'h08};
            @(posedge clk);
            oc_w <= 1'b0;
        end
        {sr, ss} = 2'b00;
        for (i = 0; i < 60 && done !== 1'b1; i++) begin
            @(negedge clk);
            sr |= req;
            ss |= w ? dwr : drd;
            check("wrong strobe", w ? drd : dwr, 1'b0);
        end
        if (i == 60) begin
            num_errors++;
            wrap_up;
        end
        check("request", sr, 1'b1);
        check("strobe", ss, 1'b1);
        check("req drop", req, 1'b0);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rand_phase(500);
        $display("test random pins ended");
        for (k = 0; k < 12; k++)
            dma_byte(2'(k % 3), 1'((k / 3) % 2), 1'(k / 6), 4'(k % 4 * 3));
        repeat (4) @(posedge clk);
        check("bytes", n_bytes[7:0], exp_bytes[7:0]);
        $display("test dma handshake ended");
        strap <= 1'b1;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rand_phase(500);
        $display("test strap high ended");
        wrap_up;
    end
endmodule
